// [rtl/warmup_pkg.sv]
package warmup_pkg;

    // ------------------------------------------------------------
    // Upper timer control fields
    // ------------------------------------------------------------
    localparam int UPPER_INIT_BIT = 7;
    localparam int UPPER_RUN_BIT = 3;
    localparam int UPPER_MODE_LSB = 0;
    localparam logic [2:0] UPPER_MODE_WARMUP = 3'h5;
    localparam logic [7:0] UPPER_CTRL_RESET = 8'h00;

    // ------------------------------------------------------------
    // Lower timer control fields
    // ------------------------------------------------------------
    localparam int LOWER_INIT_BIT = 7;
    localparam int LOWER_SRC_LSB = 4;
    localparam int LOWER_MODE_LSB = 0;
    localparam logic [2:0] LOWER_SRC_SLOW = 3'h4;
    localparam logic [2:0] LOWER_SRC_FAST = 3'h6;
    localparam logic [2:0] LOWER_MODE_CASCADE = 3'h3;
    localparam logic [7:0] LOWER_CTRL_RESET = 8'h00;

    // ------------------------------------------------------------
    // Compare limits and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] COMPARE_HIGH_MIN = 8'h01;
    localparam logic [7:0] COMPARE_HIGH_MAX = 8'hff;
    localparam logic [15:0] COMPARE_RESET = 16'hff00;
    localparam logic [15:0] COUNT_RESET = 16'h0000;

    typedef enum logic [1:0] {
        SRC_NONE,
        SRC_SLOW,
        SRC_FAST
    } source_t;

endpackage

// [rtl/source_tick_select.sv]
`timescale 1ns/1ps
// Picks the count enable of the selected source clock; registered so the
// count edge never depends on a same-cycle control write.
module source_tick_select (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire warmup_pkg::source_t source,
    input wire logic slow_clock_tick,
    input wire logic fast_clock_tick,
    output logic tick
);

    typedef struct packed {
        logic tick;
    } state_t;

    state_t state;
    state_t next_state;

    always_comb begin
        next_state = state;
        unique case (source)
            warmup_pkg::SRC_SLOW: next_state.tick = slow_clock_tick;
            warmup_pkg::SRC_FAST: next_state.tick = fast_clock_tick;
            default: next_state.tick = 1'b0;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign tick = state.tick;

endmodule

// [rtl/oscillator_warmup_counter.sv]
`timescale 1ns/1ps
// Summary of operation
// R1: Software enables slow oscillator before slow warm-up.
// R2: Software enables fast oscillator before fast warm-up.
// R3: Setting the upper run bit starts counting.
// R4: On compare match clear counter, pulse interrupt.
// R5: Slow switch: stop timer, select slow, stop fast.
// R6: Fast switch: stop timer, select fast, stop slow.
// R7: Lower control 43H: slow source, cascade mode.
// R8: Lower control 63H: fast source, cascade mode.
// R9: Upper control 05H selects warm-up mode.
// R10: Compare range 0100H to FF00H.
// R11: Same range gives fast-clock warm-up times.
// R12: Only the compare upper byte is matched.
// R13: Software keeps both flip-flop init bits zero.
// R14: Clearing run bit stops and holds the count.
module oscillator_warmup_counter #(
    parameter int COUNT_WIDTH = 16
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic upper_timer_control_write,
    input wire logic [7:0] upper_timer_control_data,
    input wire logic lower_timer_control_write,
    input wire logic [7:0] lower_timer_control_data,
    input wire logic warmup_compare_write,
    input wire logic [15:0] warmup_compare_data,
    input wire logic slow_clock_tick,
    input wire logic fast_clock_tick,
    output logic timer_match_irq,
    output logic upper_timer_run,
    output logic warmup_active,
    output logic [15:0] count_value,
    output logic [7:0] upper_timer_control,
    output logic [7:0] lower_timer_control,
    output logic [7:0] warmup_compare_high,
    output logic [7:0] warmup_compare_low
);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    // The match compares one upper byte against a 16-bit count; other
    // widths would break the documented warm-up times.
    if (COUNT_WIDTH != 16) begin : g_width_check
        $error("oscillator_warmup_counter: COUNT_WIDTH must be 16");
    end
    // The source field must tell the two clocks apart, or one warm-up
    // direction would count on the wrong oscillator
    if (warmup_pkg::LOWER_SRC_SLOW == warmup_pkg::LOWER_SRC_FAST) begin : g_source_check
        $error("oscillator_warmup_counter: source codes must differ");
    end
    // A zero minimum would let a zero compare match on the first tick
    if (warmup_pkg::COMPARE_HIGH_MIN == 8'h00) begin : g_min_check
        $error("oscillator_warmup_counter: compare minimum must be nonzero");
    end
    if (warmup_pkg::COMPARE_HIGH_MIN > warmup_pkg::COMPARE_HIGH_MAX) begin : g_range_check
        $error("oscillator_warmup_counter: compare minimum above maximum");
    end
    // The run bit must sit outside the mode field so that the set-up code
    // and the start code decode to the same mode
    if (warmup_pkg::UPPER_RUN_BIT < warmup_pkg::UPPER_MODE_LSB + 3) begin : g_run_check
        $error("oscillator_warmup_counter: run bit overlaps mode field");
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] upper_ctrl;
        logic [7:0] lower_ctrl;
        logic [7:0] cmp_high;
        logic [7:0] cmp_low;
        logic [15:0] count;
        logic irq;
        logic active;
    } state_t;

    state_t state;
    state_t next_state;

    warmup_pkg::source_t source;
    logic tick;
    logic mode_ok;
    logic run;
    logic [7:0] match_high;
    logic [2:0] upper_mode;
    logic [2:0] lower_mode;
    logic [2:0] lower_source;
    logic at_match;
    logic count_enable;
    logic [15:0] count_plus_one;

    // ------------------------------------------------------------
    // Control field views
    // ------------------------------------------------------------
    // Bit 7 of each control byte is a flip-flop init bit; warm-up mode
    // drives no timer output, so it is kept for readback only
    assign upper_mode = state.upper_ctrl[warmup_pkg::UPPER_MODE_LSB +: 3];
    assign lower_mode = state.lower_ctrl[warmup_pkg::LOWER_MODE_LSB +: 3];
    assign lower_source = state.lower_ctrl[warmup_pkg::LOWER_SRC_LSB +: 3];
    assign run = state.upper_ctrl[warmup_pkg::UPPER_RUN_BIT];

    // ------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------
    // An unlisted source code selects no tick, so the count cannot start
    always_comb begin
        unique case (lower_source)
            warmup_pkg::LOWER_SRC_SLOW: source = warmup_pkg::SRC_SLOW; // [R7]
            warmup_pkg::LOWER_SRC_FAST: source = warmup_pkg::SRC_FAST; // [R8] [R11]
            default: source = warmup_pkg::SRC_NONE;
        endcase
    end

    // Warm-up needs both halves configured: upper in warm-up, lower cascaded
    assign mode_ok = (upper_mode == warmup_pkg::UPPER_MODE_WARMUP)
                     && (lower_mode == warmup_pkg::LOWER_MODE_CASCADE); // [R9]

    // ------------------------------------------------------------
    // Match detection
    // ------------------------------------------------------------
    // A zero upper byte would match at once; it is raised to the minimum
    assign match_high = (state.cmp_high < warmup_pkg::COMPARE_HIGH_MIN)
                        ? warmup_pkg::COMPARE_HIGH_MIN : state.cmp_high; // [R10]
    // Only the upper byte decides: the count's low byte is zero at the
    // match point and the stored low compare byte takes no part
    assign at_match = (state.count == {match_high, 8'h00}); // [R12]
    // The stored run bit gates each tick, so a stop write holds the count
    // from the edge after the one that stores it, including a tick already in the selector
    assign count_enable = state.active && run && tick; // [R3] [R14]
    assign count_plus_one = state.count + 16'h0001;

    // ------------------------------------------------------------
    // Source selection
    // ------------------------------------------------------------
    // The selector registers the tick, which costs one edge of latency but
    // keeps a same-cycle control write out of the count path
    source_tick_select u_tick (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .source(source),
        .slow_clock_tick(slow_clock_tick),
        .fast_clock_tick(fast_clock_tick),
        .tick(tick)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_state.irq = 1'b0;
        if (upper_timer_control_write) begin
            next_state.upper_ctrl = upper_timer_control_data; // [R3] [R14]
        end
        if (lower_timer_control_write) begin
            next_state.lower_ctrl = lower_timer_control_data;
        end
        if (warmup_compare_write) begin
            next_state.cmp_high = warmup_compare_data[15:8];
            next_state.cmp_low = warmup_compare_data[7:0];
        end
        // Qualified from the stored set-up, so it follows a write by one edge
        next_state.active = run && mode_ok && (source != warmup_pkg::SRC_NONE);
        // A stopped timer keeps its count, and no match can fire until it runs again
        if (count_enable) begin
            if (at_match) begin
                next_state.count = warmup_pkg::COUNT_RESET; // [R4]
                next_state.irq = 1'b1; // [R4]
            end else begin
                next_state.count = count_plus_one; // [R3]
            end
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // With the compare upper byte at N the count reaches N*256 after that
    // many source ticks, and the next tick clears it and raises the match
    // pulse. An input tick reaches the count two edges after it is driven.
    // Rewriting the compare word while running takes effect at once; a
    // value already passed is met only after the count wraps, so firmware
    // should stop the timer before changing it.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            // Compare starts at its largest setting, so a start without a
            // compare write still ends in a match
            state.upper_ctrl <= warmup_pkg::UPPER_CTRL_RESET;
            state.lower_ctrl <= warmup_pkg::LOWER_CTRL_RESET;
            state.cmp_high <= warmup_pkg::COMPARE_RESET[15:8];
            state.cmp_low <= warmup_pkg::COMPARE_RESET[7:0];
            state.count <= warmup_pkg::COUNT_RESET;
            state.irq <= 1'b0;
            state.active <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Every output is a register field; nothing here adds logic
    assign timer_match_irq = state.irq;
    assign upper_timer_run = state.upper_ctrl[warmup_pkg::UPPER_RUN_BIT];
    assign warmup_active = state.active;
    assign count_value = state.count;
    assign upper_timer_control = state.upper_ctrl;
    assign lower_timer_control = state.lower_ctrl;
    assign warmup_compare_high = state.cmp_high;
    assign warmup_compare_low = state.cmp_low;

endmodule

// [verification/warmup_assertions.sv]
`timescale 1ns/1ps
module warmup_checker (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic upper_timer_control_write,
    input wire logic [7:0] upper_timer_control_data,
    input wire logic timer_match_irq,
    input wire logic upper_timer_run,
    input wire logic warmup_active,
    input wire logic [15:0] count_value,
    input wire logic [7:0] upper_timer_control,
    input wire logic [7:0] warmup_compare_high
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // ----------------------------------------
    // Stopped: run low for two cycles; the run bit already gates a tick in flight
    // ----------------------------------------
    sequence s_stopped;
        !upper_timer_run [*2];
    endsequence
    a_run_from_write: assert property (upper_timer_control_write |=>
        upper_timer_run == $past(upper_timer_control_data[3])) else $error("run bit lost");
    a_count_steps: assert property ($changed(count_value) && !timer_match_irq |->
        count_value == $past(count_value) + 16'h0001) else $error("count jumped");
    a_irq_clears_count: assert property (timer_match_irq |-> count_value == 16'h0000)
        else $error("count not cleared on match");
    a_irq_one_cycle: assert property (timer_match_irq |=> !timer_match_irq)
        else $error("match pulse too long");
    a_match_high_only: assert property (timer_match_irq |->
        $past(count_value) == {$past(warmup_compare_high), 8'h00}) else $error("bad match");
    a_stop_holds: assert property (s_stopped |=> $stable(count_value))
        else $error("count moved while stopped");
    a_active_mode: assert property ($rose(warmup_active) |-> upper_timer_run &&
        upper_timer_control[2:0] == warmup_pkg::UPPER_MODE_WARMUP) else $error("bad mode");
    a_count_in_range: assert property (warmup_active |->
        count_value <= {warmup_compare_high, 8'h00}) else $error("count past compare");
endmodule
bind oscillator_warmup_counter warmup_checker i_warmup_checker (.ref_clk(ref_clk),
    .rst_n(rst_n), .upper_timer_control_write(upper_timer_control_write),
    .upper_timer_control_data(upper_timer_control_data), .timer_match_irq(timer_match_irq),
    .upper_timer_run(upper_timer_run), .warmup_active(warmup_active),
    .count_value(count_value), .upper_timer_control(upper_timer_control),
    .warmup_compare_high(warmup_compare_high));

// [verification/oscillator_warmup_counter_tb.sv]
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin \
    $display("[FAIL] %s exp %h got %h", nm, ex, got); err_count++; end end
module oscillator_warmup_counter_tb;
    logic ref_clk = 0, rst_n = 0, uw = 0, lw = 0, cw = 0, st = 0, ft = 0;
    logic [7:0] ud = 8'h00, ld = 8'h00;
    logic [15:0] cd = 16'h0000, count_value;
    logic irq, run, active;
    logic [7:0] uc, lc, ch, cl;
    int err_count = 0, n_compared = 0, irqs = 0;
    initial begin
        forever #2 ref_clk = ~ref_clk;
    end
    oscillator_warmup_counter i_oscillator_warmup_counter (.ref_clk(ref_clk), .rst_n(rst_n),
        .upper_timer_control_write(uw), .upper_timer_control_data(ud),
        .lower_timer_control_write(lw), .lower_timer_control_data(ld),
        .warmup_compare_write(cw), .warmup_compare_data(cd), .slow_clock_tick(st),
        .fast_clock_tick(ft), .timer_match_irq(irq), .upper_timer_run(run),
        .warmup_active(active), .count_value(count_value), .upper_timer_control(uc),
        .lower_timer_control(lc), .warmup_compare_high(ch), .warmup_compare_low(cl));
    always @(posedge ref_clk) begin
        if (irq === 1'b1) begin
            irqs <= irqs + 1;
        end
    end
    // ----------------------------------------
    // Access tasks
    // ----------------------------------------
    task automatic wr(input int sel, input logic [15:0] d);
        @(negedge ref_clk);
        uw = (sel == 0);
        lw = (sel == 1);
        cw = (sel == 2);
        ud = d[7:0];
        ld = d[7:0];
        cd = d;
        @(negedge ref_clk);
        {uw, lw, cw} = 3'h0;
    endtask
    // Ticks back to back, then settle past the two-edge count latency
    task automatic ticks(input int n, input logic fast);
        repeat (n) begin
            @(negedge ref_clk);
            st = !fast;
            ft = fast;
        end
        @(negedge ref_clk);
        {st, ft} = 2'h0;
        repeat (3) @(negedge ref_clk);
    endtask
    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (20) @(negedge ref_clk);
        rst_n = 1;
        `CHK("cmp_high_rst", 8'hff, ch)
        `CHK("cmp_low_rst", 8'h00, cl)
        `CHK("count_rst", 16'h0000, count_value)
        // Slow oscillator taken as running; both init bits kept at zero
        wr(1, 16'h0043);
        wr(2, 16'h0155);
        `CHK("lower_ctrl", 8'h43, lc)
        `CHK("cmp_low_kept", 8'h55, cl)
        wr(0, 16'h0005);
        `CHK("idle_not_active", 1'b0, active)
        wr(0, 16'h000d);
        @(negedge ref_clk);
        `CHK("active", 1'b1, active)
        `CHK("upper_ctrl", 8'h0d, uc)
        ticks(40, 1);
        `CHK("wrong_source", 16'h0000, count_value)
        ticks(100, 0);
        `CHK("count_run", 16'h0064, count_value)
        wr(0, 16'h0005);
        `CHK("run_off", 1'b0, run)
        ticks(50, 0);
        `CHK("count_held", 16'h0064, count_value)
        wr(0, 16'h000d);
        ticks(156, 0);
        `CHK("count_min", 16'h0100, count_value)
        `CHK("no_irq_low_byte", 0, irqs)
        ticks(1, 0);
        `CHK("clear_min", 16'h0000, count_value)
        `CHK("irq_min", 1, irqs)
        // Match handler of the slow switch stops the timer first
        wr(0, 16'h0005);
        `CHK("handler_stop", 1'b0, run)
        // An unlisted source code must keep the counter idle
        wr(1, 16'h0003);
        wr(0, 16'h000d);
        @(negedge ref_clk);
        `CHK("no_source_idle", 1'b0, active)
        wr(0, 16'h0005);
        // Fast oscillator taken as running; both init bits kept at zero
        wr(1, 16'h0063);
        wr(2, 16'hff00);
        wr(0, 16'h000d);
        ticks(65280, 1);
        `CHK("count_max", 16'hff00, count_value)
        ticks(1, 1);
        `CHK("clear_max", 16'h0000, count_value)
        `CHK("irq_max", 2, irqs)
        // Match handler of the fast switch stops the timer first
        wr(0, 16'h0005);
        `CHK("handler_stop_fast", 1'b0, run)
        tally_and_finish;
    end
endmodule
